// ---- rtl/dpfc_consts.svh ----
/*
 * Register offsets, field positions, reset values, command codes and timing
 * figures of the payload feature control block.
 * Assumes it is included by bare name by the block, the checker and the testbench.
 */
`ifndef DPFC_CONSTS_SVH
`define DPFC_CONSTS_SVH

// Register offsets on the serial command port.
`define DPFC_OFS_PIPE_DYN_LEN 5'h1C
`define DPFC_OFS_FEATURE 5'h1D

// Reset values and writable masks; reserved bits are zero in the masks.
`define DPFC_RST_PIPE_DYN_LEN 8'h00
`define DPFC_RST_FEATURE 8'h00
`define DPFC_MASK_PIPE_DYN_LEN 8'h3F
`define DPFC_MASK_FEATURE 8'h07

// Field positions of the feature register.
`define DPFC_BIT_GLOBAL_VAR_LEN 2
`define DPFC_BIT_ACK_PAYLOAD 1
`define DPFC_BIT_NO_ACK_CMD 0

// Command byte codes: read and write register carry the offset in bits 4:0.
`define DPFC_CMD_READ_REG 3'h0
`define DPFC_CMD_WRITE_REG 3'h1
`define DPFC_CMD_TX_UNACKED 8'hB0

// Air data rate encodings on the rate input.
`define DPFC_RATE_1M 2'h0
`define DPFC_RATE_2M 2'h1
`define DPFC_RATE_250K 2'h2

// Timing figures in microseconds and the clock rate in MHz.
`define DPFC_LISTEN_US 250
`define DPFC_LISTEN_SLOW_US 500
`define DPFC_ARD_STEP_US 250
`define DPFC_CLK_MHZ 10

`endif

// ---- rtl/dpfc_pkg.sv ----
/*
 * Types shared by the payload feature control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dpfc_pkg;

   // Acknowledge wait sequencer of the primary transmitter.
   typedef enum logic [2:0] {
      DPFC_IDLE = 3'b000,
      DPFC_TX = 3'b001,
      DPFC_LISTEN = 3'b010,
      DPFC_RXPKT = 3'b011,
      DPFC_STANDBY2 = 3'b100
   } dpfc_state_t;

endpackage

// ---- rtl/dpfc_ctrl.sv ----
/*
 * Payload feature control: serial register port for the feature and per-pipe
 * variable length registers, effective enable decode, acknowledge wait and
 * retransmit sequencing, and the receive data ready flag.
 * Assumes a mode 0 serial host clocking well below a quarter of mclk, and a
 * radio core on mclk that gives one-cycle event pulses.
 */
// Summary of operation
// R01 - Pipe bits 2..0 enable variable length when global and auto-ack both set.
// R02 - Feature bit 2, reset 0, globally enables variable payload length.
// R03 - Feature bit 1, reset 0, enables payload in acknowledgements.
// R04 - Feature bit 0 enables the unacknowledged write command; bits 7:3 reserved.
// R05 - Host: at 2 Mbps, ack payload over 15 bytes needs delay of 500 us.
// R06 - Host: at 1 Mbps, ack payload over 5 bytes needs delay of 500 us.
// R07 - Host: at 250 kbps the retransmit delay is always at least 500 us.
// R08 - Transmitter listens 250 us, 500 us at 250 kbps; delay is total wait.
// R09 - On address match stay receiving until packet end unless delay expires.
// R10 - After listening, standby until delay ends, then transmit again.
// R11 - Receive data ready flag sets on every new received packet.
// R12 - Host reads payload, clears flag, checks buffer status, repeats.
// R13 - Ack payloads use variable length; pipe 0 variable length must be on.
// R14 - Pipe bits 5..3 likewise enable pipes 5..3; bits 7:6 reserved zero.
// R15 - Reserved bits of both registers ignore writes and read as zero.
`timescale 1ns/1ps
`include "dpfc_consts.svh"

module dpfc_ctrl #(
   parameter int PIPES = 6,
   parameter int LISTEN_CYC = `DPFC_LISTEN_US * `DPFC_CLK_MHZ,
   parameter int LISTEN_SLOW_CYC = `DPFC_LISTEN_SLOW_US * `DPFC_CLK_MHZ,
   parameter int ARD_STEP_CYC = `DPFC_ARD_STEP_US * `DPFC_CLK_MHZ
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Serial command port pins.
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Configuration from the rest of the register map.
   input wire logic [PIPES-1:0] pipe_auto_ack_en,
   input wire logic [3:0] retransmit_delay,
   input wire logic [1:0] air_rate,
   // Radio core events.
   input wire logic tx_request,
   input wire logic tx_done,
   input wire logic addr_match,
   input wire logic packet_end,
   input wire logic ack_received,
   input wire logic rx_packet_stored,
   input wire logic rx_flag_clear,
   // Decoded enables and status.
   output logic [PIPES-1:0] pipe_var_len_active,
   output logic ack_payload_active,
   output logic write_tx_payload_unacked,
   output logic receive_data_ready_flag,
   // Primary transmitter sequencing.
   output logic radio_tx_on,
   output logic radio_rx_on,
   output logic radio_standby2,
   output logic retransmit_pulse
);

   // Total acknowledge wait in cycles: one step per delay code plus one.
   function automatic logic [19:0] ard_cycles(input logic [3:0] code);
      ard_cycles = 20'((32'(code) + 32'd1) * ARD_STEP_CYC);
   endfunction

   // Two-flop synchronisers; a third stage feeds the clock edge detector only.
   logic [2:0] sck_sync_reg;
   logic [1:0] cs_sync_reg;
   logic [1:0] mosi_sync_reg;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_sync_reg <= 3'h0;
         cs_sync_reg <= 2'h3;
         mosi_sync_reg <= 2'h0;
      end else begin
         sck_sync_reg <= {sck_sync_reg[1:0], spi_sck};
         cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
         mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      end
   end

   logic sck_rise;
   logic sck_fall;
   logic cs_active;
   assign sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
   assign sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
   assign cs_active = ~cs_sync_reg[1];

   // Serial shifter and register file state.
   logic [7:0] rx_shift_reg, rx_shift_next;
   logic [7:0] tx_shift_reg, tx_shift_next;
   logic [2:0] bit_cnt_reg, bit_cnt_next;
   logic first_byte_reg, first_byte_next;
   logic [7:0] cmd_reg, cmd_next;
   logic miso_reg, miso_next;
   logic miso_oe_reg, miso_oe_next;
   logic [7:0] feature_enables_reg, feature_enables_next;
   logic [7:0] pipe_dynamic_length_enables_reg, pipe_dynamic_length_enables_next;
   logic unacked_reg, unacked_next;

   // A whole byte has arrived on this rising clock edge.
   logic [7:0] byte_in;
   logic byte_done;
   assign byte_in = {rx_shift_reg[6:0], mosi_sync_reg[1]};
   assign byte_done = cs_active & sck_rise & (bit_cnt_reg == 3'h7);

   // Register read mux; unmapped offsets read zero.
   function automatic logic [7:0] reg_read(input logic [4:0] ofs, input logic [7:0] feat,
                                           input logic [7:0] dyn);
      if (ofs == `DPFC_OFS_FEATURE) reg_read = feat;
      else if (ofs == `DPFC_OFS_PIPE_DYN_LEN) reg_read = dyn;
      else reg_read = 8'h00;
   endfunction

   // Serial protocol: command byte, then data bytes all aimed at the same register.
   always_comb begin
      rx_shift_next = rx_shift_reg;
      tx_shift_next = tx_shift_reg;
      bit_cnt_next = bit_cnt_reg;
      first_byte_next = first_byte_reg;
      cmd_next = cmd_reg;
      miso_next = miso_reg;
      miso_oe_next = cs_active;
      feature_enables_next = feature_enables_reg;
      pipe_dynamic_length_enables_next = pipe_dynamic_length_enables_reg;
      unacked_next = 1'b0;
      if (!cs_active) begin
         bit_cnt_next = 3'h0;
         first_byte_next = 1'b1;
         tx_shift_next = 8'h00;
         miso_next = 1'b0;
      end else begin
         if (sck_rise) begin
            rx_shift_next = byte_in;
            bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
         end
         if (byte_done && first_byte_reg) begin
            first_byte_next = 1'b0;
            cmd_next = byte_in;
            tx_shift_next = reg_read(byte_in[4:0], feature_enables_reg,
                                     pipe_dynamic_length_enables_reg);
            // The unacknowledged write is honoured only while enabled.
            if (byte_in == `DPFC_CMD_TX_UNACKED &&
                feature_enables_reg[`DPFC_BIT_NO_ACK_CMD]) begin // R04
               unacked_next = 1'b1;
            end
         end else if (byte_done && cmd_reg[7:5] == `DPFC_CMD_WRITE_REG) begin
            // Masks drop reserved bits so they always read back as zero.
            if (cmd_reg[4:0] == `DPFC_OFS_FEATURE) begin
               feature_enables_next = byte_in & `DPFC_MASK_FEATURE; // R02 R03 R04 R15
            end else if (cmd_reg[4:0] == `DPFC_OFS_PIPE_DYN_LEN) begin
               pipe_dynamic_length_enables_next = byte_in & `DPFC_MASK_PIPE_DYN_LEN; // R14 R15
            end
         end else if (byte_done && cmd_reg[7:5] == `DPFC_CMD_READ_REG) begin
            tx_shift_next = reg_read(cmd_reg[4:0], feature_enables_reg,
                                     pipe_dynamic_length_enables_reg);
         end
         // Data changes on the falling edge so the host samples it stable.
         if (sck_fall) begin
            miso_next = tx_shift_reg[7];
            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_shift_reg <= 8'h00;
         tx_shift_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         first_byte_reg <= 1'b1;
         cmd_reg <= 8'h00;
         miso_reg <= 1'b0;
         miso_oe_reg <= 1'b0;
         feature_enables_reg <= `DPFC_RST_FEATURE;
         pipe_dynamic_length_enables_reg <= `DPFC_RST_PIPE_DYN_LEN;
         unacked_reg <= 1'b0;
      end else begin
         rx_shift_reg <= rx_shift_next;
         tx_shift_reg <= tx_shift_next;
         bit_cnt_reg <= bit_cnt_next;
         first_byte_reg <= first_byte_next;
         cmd_reg <= cmd_next;
         miso_reg <= miso_next;
         miso_oe_reg <= miso_oe_next;
         feature_enables_reg <= feature_enables_next;
         pipe_dynamic_length_enables_reg <= pipe_dynamic_length_enables_next;
         unacked_reg <= unacked_next;
      end
   end

   // Effective enables and the data ready flag.
   logic [PIPES-1:0] var_len_reg, var_len_next;
   logic ack_pay_reg, ack_pay_next;
   logic rx_ready_reg, rx_ready_next;
   always_comb begin
      var_len_next = pipe_dynamic_length_enables_reg[PIPES-1:0] & pipe_auto_ack_en &
                     {PIPES{feature_enables_reg[`DPFC_BIT_GLOBAL_VAR_LEN]}}; // R01 R14
      // Ack payloads are variable length, so they need pipe 0 variable length.
      ack_pay_next = feature_enables_reg[`DPFC_BIT_ACK_PAYLOAD] & var_len_next[0]; // R13
      // A new packet sets the flag even in the cycle the host clears it.
      rx_ready_next = rx_packet_stored | (rx_ready_reg & ~rx_flag_clear); // R11
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         var_len_reg <= '0;
         ack_pay_reg <= 1'b0;
         rx_ready_reg <= 1'b0;
      end else begin
         var_len_reg <= var_len_next;
         ack_pay_reg <= ack_pay_next;
         rx_ready_reg <= rx_ready_next;
      end
   end

   // Acknowledge wait sequencer state.
   dpfc_pkg::dpfc_state_t state_reg, state_next;
   logic [19:0] wait_cnt_reg, wait_cnt_next;
   logic retx_reg, retx_next;
   logic [19:0] ard_total;
   logic [19:0] listen_total;
   assign ard_total = ard_cycles(retransmit_delay);
   assign listen_total = (air_rate == `DPFC_RATE_250K) ? 20'(LISTEN_SLOW_CYC)
                                                       : 20'(LISTEN_CYC); // R08

   // The wait count starts when the packet leaves and covers listen and standby.
   always_comb begin
      state_next = state_reg;
      wait_cnt_next = 20'(wait_cnt_reg + 20'h00001);
      retx_next = 1'b0;
      unique case (state_reg)
         dpfc_pkg::DPFC_IDLE: begin
            wait_cnt_next = 20'h00000;
            if (tx_request) state_next = dpfc_pkg::DPFC_TX;
         end
         dpfc_pkg::DPFC_TX: begin
            wait_cnt_next = 20'h00000;
            if (tx_done) state_next = dpfc_pkg::DPFC_LISTEN;
         end
         dpfc_pkg::DPFC_LISTEN: begin
            if (addr_match) begin
               state_next = dpfc_pkg::DPFC_RXPKT; // R09
            end else if (wait_cnt_next >= listen_total) begin
               state_next = dpfc_pkg::DPFC_STANDBY2; // R10
            end
         end
         dpfc_pkg::DPFC_RXPKT: begin
            if (packet_end && ack_received) begin
               state_next = dpfc_pkg::DPFC_IDLE;
            end else if (wait_cnt_next >= ard_total) begin
               // Delay expiry cuts the packet short and forces a resend.
               state_next = dpfc_pkg::DPFC_TX; // R09
               retx_next = 1'b1;
            end else if (packet_end) begin
               state_next = dpfc_pkg::DPFC_STANDBY2; // R10
            end
         end
         dpfc_pkg::DPFC_STANDBY2: begin
            if (wait_cnt_next >= ard_total) begin
               state_next = dpfc_pkg::DPFC_TX; // R08 R10
               retx_next = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= dpfc_pkg::DPFC_IDLE;
         wait_cnt_reg <= 20'h00000;
         retx_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wait_cnt_reg <= wait_cnt_next;
         retx_reg <= retx_next;
      end
   end

   // Outputs from flip-flops; the radio controls are decoded from the state register.
   assign spi_miso = miso_reg;
   assign spi_miso_oe = miso_oe_reg;
   assign pipe_var_len_active = var_len_reg;
   assign ack_payload_active = ack_pay_reg;
   assign write_tx_payload_unacked = unacked_reg;
   assign receive_data_ready_flag = rx_ready_reg;
   assign radio_tx_on = (state_reg == dpfc_pkg::DPFC_TX);
   assign radio_rx_on = (state_reg == dpfc_pkg::DPFC_LISTEN) |
                        (state_reg == dpfc_pkg::DPFC_RXPKT);
   assign radio_standby2 = (state_reg == dpfc_pkg::DPFC_STANDBY2);
   assign retransmit_pulse = retx_reg;

endmodule

// ---- bench/dpfc_ctrl_checker.sv ----
/*
 * Concurrent checks on the ports of the payload feature control block.
 * Assumes it is bound to dpfc_ctrl and sees only its ports.
 */
`timescale 1ns/1ps
`include "dpfc_consts.svh"

module dpfc_ctrl_checker #(
   parameter int PIPES = 6,
   parameter int LISTEN_CYC = 10,
   parameter int LISTEN_SLOW_CYC = 20,
   parameter int ARD_STEP_CYC = 10
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Configuration and radio events.
   input wire logic [PIPES-1:0] pipe_auto_ack_en,
   input wire logic [3:0] retransmit_delay,
   input wire logic [1:0] air_rate,
   input wire logic tx_request,
   input wire logic tx_done,
   input wire logic addr_match,
   input wire logic packet_end,
   input wire logic ack_received,
   input wire logic rx_packet_stored,
   input wire logic rx_flag_clear,
   // Outputs under watch.
   input wire logic [PIPES-1:0] pipe_var_len_active,
   input wire logic ack_payload_active,
   input wire logic write_tx_payload_unacked,
   input wire logic receive_data_ready_flag,
   input wire logic radio_tx_on,
   input wire logic radio_rx_on,
   input wire logic radio_standby2,
   input wire logic retransmit_pulse
);
   logic [15:0] since_reg, since_next;
   logic seen_reg, seen_next;
   int listen_len, total_len;
   logic idle;

   // Cycles since the packet left the air, and whether an address matched since then.
   always_comb begin
      since_next = since_reg + 16'h0001;
      seen_next = seen_reg | (addr_match & radio_rx_on);
      if (tx_done & radio_tx_on) begin
         since_next = 16'h0000;
         seen_next = 1'b0;
      end
   end

   // The counter wraps in long idle spells, which is harmless since it restarts per attempt.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         since_reg <= 16'h0000;
         seen_reg <= 1'b0;
      end else begin
         since_reg <= since_next;
         seen_reg <= seen_next;
      end
   end

   assign listen_len = (air_rate == `DPFC_RATE_250K) ? LISTEN_SLOW_CYC : LISTEN_CYC;
   assign total_len = (int'(retransmit_delay) + 1) * ARD_STEP_CYC;
   assign idle = !(radio_tx_on | radio_rx_on | radio_standby2);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   AST_LISTEN_LEN: assert property ($rose(radio_standby2) && !seen_reg && total_len > listen_len
      |-> since_reg == listen_len) else $error("listen window length wrong");
   AST_RETX_TIME: assert property (retransmit_pulse && total_len > listen_len
      |-> since_reg == total_len) else $error("resend not at end of delay");
   AST_RETX_TX: assert property (retransmit_pulse
      |-> radio_tx_on && ($past(radio_standby2) || $past(radio_rx_on)))
      else $error("resend without tx");
   AST_RX_HOLD: assert property (radio_rx_on && seen_reg && !packet_end && since_reg + 1 < total_len
      |=> radio_rx_on) else $error("receive left before packet end");
   AST_ACK_DONE: assert property (radio_rx_on && seen_reg && packet_end && ack_received
      && since_reg + 1 < total_len |=> idle) else $error("no idle after ack");
   AST_TX_START: assert property (idle && tx_request |=> radio_tx_on && !retransmit_pulse)
      else $error("transmit did not start");
   AST_FLAG_SET: assert property (rx_packet_stored |=> receive_data_ready_flag)
      else $error("data ready flag not set");
   AST_FLAG_CLR: assert property (rx_flag_clear && !rx_packet_stored |=> !receive_data_ready_flag)
      else $error("data ready flag not cleared");
   AST_PIPE_GATE: assert property ((pipe_var_len_active & ~$past(pipe_auto_ack_en)) == '0)
      else $error("pipe enable without auto ack");
   AST_ACKPAY: assert property (ack_payload_active |-> pipe_var_len_active[0])
      else $error("ack payload without pipe 0 length");
   AST_UNACKED: assert property (write_tx_payload_unacked |=> !write_tx_payload_unacked)
      else $error("unacked command pulse too long");

   // Main scenarios reached.
   COV_RETX: cover property (retransmit_pulse);
   COV_UNACKED: cover property (write_tx_payload_unacked);
   COV_ACK: cover property (radio_rx_on && seen_reg && packet_end && ack_received);
endmodule

bind dpfc_ctrl dpfc_ctrl_checker #(.PIPES(PIPES), .LISTEN_CYC(LISTEN_CYC),
   .LISTEN_SLOW_CYC(LISTEN_SLOW_CYC), .ARD_STEP_CYC(ARD_STEP_CYC)) u_chk (
   .mclk(mclk), .sys_rst(sys_rst), .pipe_auto_ack_en(pipe_auto_ack_en),
   .retransmit_delay(retransmit_delay), .air_rate(air_rate), .tx_request(tx_request),
   .tx_done(tx_done), .addr_match(addr_match), .packet_end(packet_end),
   .ack_received(ack_received), .rx_packet_stored(rx_packet_stored),
   .rx_flag_clear(rx_flag_clear), .pipe_var_len_active(pipe_var_len_active),
   .ack_payload_active(ack_payload_active), .write_tx_payload_unacked(write_tx_payload_unacked),
   .receive_data_ready_flag(receive_data_ready_flag), .radio_tx_on(radio_tx_on),
   .radio_rx_on(radio_rx_on), .radio_standby2(radio_standby2),
   .retransmit_pulse(retransmit_pulse));

// ---- bench/dpfc_host_model.sv ----
/*
 * Host microcontroller model driving the mode 0 serial command port.
 * Assumes mclk at 10 MHz; serial clock halves last 4 mclk, well above the 3 needed.
 */
`timescale 1ns/1ps

module dpfc_host_model (
   // Clock in.
   input wire logic mclk,
   // Serial pins.
   output logic sck,
   output logic cs_n,
   output logic mosi,
   input wire logic miso
);
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // One frame of nb bytes, MSB first; read data is sampled on the rises of byte 2.
   task automatic xfer(input int nb, input logic [15:0] dout, output logic [7:0] din);
      int i;
      din = 8'h00;
      @(negedge mclk);
      cs_n = 1'b0;
      repeat (4) @(negedge mclk);
      for (i = 0; i < nb * 8; i++) begin
         mosi = dout[15 - i];
         repeat (4) @(negedge mclk);
         sck = 1'b1;
         if (i >= 8) din = {din[6:0], miso};
         repeat (4) @(negedge mclk);
         sck = 1'b0;
      end
      repeat (4) @(negedge mclk);
      cs_n = 1'b1;
      // A released line must not keep showing its last bit.
      mosi = ~mosi;
      repeat (4) @(negedge mclk);
   endtask
endmodule

// ---- bench/test_dpfc_ctrl.sv ----
/*
 * Self-checking testbench of the payload feature control block.
 * Assumes the host model and checker files are compiled first.
 */
`timescale 1ns/1ps
`include "dpfc_consts.svh"

module test_dpfc_ctrl;
   logic mclk = 0, sys_rst = 1, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   logic [5:0] pipe_auto_ack_en = 6'h2D;
   logic [3:0] retransmit_delay = 4'h2;
   logic [1:0] air_rate = 2'h0;
   logic tx_request = 0, tx_done = 0, addr_match = 0, packet_end = 0, ack_received = 0;
   logic rx_packet_stored = 0, rx_flag_clear = 0;
   logic [5:0] pipe_var_len_active;
   logic ack_payload_active, write_tx_payload_unacked, receive_data_ready_flag;
   logic radio_tx_on, radio_rx_on, radio_standby2, retransmit_pulse;
   logic [7:0] rd;
   int num_errors = 0, cmp_count = 0, ucnt = 0, oecnt = 0, n, r;

   dpfc_ctrl #(.LISTEN_CYC(10), .LISTEN_SLOW_CYC(20), .ARD_STEP_CYC(10)) uut (.mclk(mclk),
      .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .pipe_auto_ack_en(pipe_auto_ack_en),
      .retransmit_delay(retransmit_delay), .air_rate(air_rate), .tx_request(tx_request),
      .tx_done(tx_done), .addr_match(addr_match), .packet_end(packet_end),
      .ack_received(ack_received), .rx_packet_stored(rx_packet_stored),
      .rx_flag_clear(rx_flag_clear), .pipe_var_len_active(pipe_var_len_active),
      .ack_payload_active(ack_payload_active), .write_tx_payload_unacked(write_tx_payload_unacked),
      .receive_data_ready_flag(receive_data_ready_flag), .radio_tx_on(radio_tx_on),
      .radio_rx_on(radio_rx_on), .radio_standby2(radio_standby2),
      .retransmit_pulse(retransmit_pulse));
   dpfc_host_model host (.mclk(mclk), .sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi),
      .miso(spi_miso));

   // Clock at 10 MHz and a count of unacknowledged command pulses.
   initial begin
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) if (write_tx_payload_unacked === 1'b1) ucnt++;
   // Cycles with the data out driver on; a frame keeps it on as long as select is low.
   always @(posedge mclk) if (spi_miso_oe === 1'b1) oecnt++;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer(2, {`DPFC_CMD_WRITE_REG, a, d}, rd);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [7:0] e);
      host.xfer(2, {`DPFC_CMD_READ_REG, a, 8'h00}, rd);
      chk(16'(rd), 16'(e), "register read");
   endtask
   // Counts falling edges while a level stays high, bounded.
   task automatic span(ref logic s);
      n = 0;
      while (s === 1'b1 && n < 300) begin
         n++;
         @(negedge mclk);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Watchdog well beyond the expected run of about 2000 cycles.
   initial begin
      repeat (40000) @(posedge mclk);
      num_errors++;
      test_done();
   end

   initial begin
      repeat (4) @(negedge mclk);
      sys_rst = 0;
      repeat (2) @(negedge mclk);
      rdc(`DPFC_OFS_FEATURE, 8'h00);
      chk(16'(oecnt), 16'd136, "output enable span of one frame");
      rdc(`DPFC_OFS_PIPE_DYN_LEN, 8'h00);
      wr(`DPFC_OFS_FEATURE, 8'hFF);
      wr(`DPFC_OFS_PIPE_DYN_LEN, 8'hFF);
      rdc(`DPFC_OFS_FEATURE, 8'h07);
      rdc(`DPFC_OFS_PIPE_DYN_LEN, 8'h3F);
      rdc(5'h1E, 8'h00);
      $display("test registers done");
      chk(16'(pipe_var_len_active), 16'h002D, "pipe enables");
      chk(16'(ack_payload_active), 16'h0001, "ack payload on");
      pipe_auto_ack_en = 6'h12;
      repeat (3) @(negedge mclk);
      chk(16'(pipe_var_len_active), 16'h0012, "auto ack gate");
      chk(16'(ack_payload_active), 16'h0000, "ack payload needs pipe 0");
      wr(`DPFC_OFS_FEATURE, 8'h03);
      chk(16'(pipe_var_len_active), 16'h0000, "global length off");
      wr(`DPFC_OFS_FEATURE, 8'h01);
      host.xfer(1, {`DPFC_CMD_TX_UNACKED, 8'h00}, rd);
      chk(16'(ucnt), 16'h0001, "unacked command enabled");
      wr(`DPFC_OFS_FEATURE, 8'h00);
      host.xfer(1, {`DPFC_CMD_TX_UNACKED, 8'h00}, rd);
      chk(16'(ucnt), 16'h0001, "unacked command refused");
      $display("test enables done");
      rx_packet_stored = 1;
      @(negedge mclk);
      rx_packet_stored = 0;
      chk(16'(receive_data_ready_flag), 16'h0001, "flag set");
      rx_packet_stored = 1;
      rx_flag_clear = 1;
      @(negedge mclk);
      rx_packet_stored = 0;
      chk(16'(receive_data_ready_flag), 16'h0001, "set wins over clear");
      @(negedge mclk);
      rx_flag_clear = 0;
      chk(16'(receive_data_ready_flag), 16'h0000, "flag cleared");
      $display("test flag done");
      // Delay code 2 is 750 us scaled, above the 500 us floor of every rate.
      for (r = 0; r < 3; r++) begin
         air_rate = 2'(r);
         tx_request = 1;
         @(negedge mclk);
         tx_request = 0;
         tx_done = 1;
         @(negedge mclk);
         tx_done = 0;
         span(radio_rx_on);
         chk(16'(n), (r == 2) ? 16'd20 : 16'd10, "listen length");
         span(radio_standby2);
         chk(16'(n), (r == 2) ? 16'd10 : 16'd20, "standby length");
         chk(16'({radio_tx_on, retransmit_pulse}), 16'h0003, "resend");
         tx_done = 1;
         @(negedge mclk);
         tx_done = 0;
         addr_match = 1;
         @(negedge mclk);
         addr_match = 0;
         span(radio_rx_on);
         chk(16'(n), 16'd29, "receive until delay ends");
         chk(16'({radio_tx_on, retransmit_pulse}), 16'h0003, "resend after match");
         // A matched packet that is not an ack leaves the rest of the delay in standby.
         tx_done = 1;
         @(negedge mclk);
         tx_done = 0;
         addr_match = 1;
         @(negedge mclk);
         addr_match = 0;
         packet_end = 1;
         @(negedge mclk);
         packet_end = 0;
         span(radio_standby2);
         chk(16'(n), 16'd28, "standby after packet without ack");
         chk(16'({radio_tx_on, retransmit_pulse}), 16'h0003, "resend after no ack");
         tx_done = 1;
         @(negedge mclk);
         tx_done = 0;
         addr_match = 1;
         @(negedge mclk);
         addr_match = 0;
         packet_end = 1;
         ack_received = 1;
         @(negedge mclk);
         packet_end = 0;
         ack_received = 0;
         chk(16'({radio_tx_on, radio_rx_on, radio_standby2}), 16'h0000, "idle on ack");
      end
      $display("test sequencer done");
      // A reset in mid-run must return the written pipe register to zero.
      sys_rst = 1;
      repeat (4) @(negedge mclk);
      sys_rst = 0;
      repeat (2) @(negedge mclk);
      rdc(`DPFC_OFS_PIPE_DYN_LEN, 8'h00);
      $display("test reset done");
      test_done();
   end
endmodule
